/* cfp_host.sv */
// Purpose: Host end: waits for status, then clocks words out at ratio.
// Assumes: config_clock derived from mclk by a divider.
// Notes: Clock stops low while the user has no word ready.
`timescale 1ns/1ps
`default_nettype none
module cfp_host #(
   parameter int HALF_CYCLES = cfp_pkg::CLK_HALF_CYC,
   parameter int WAIT_CYCLES = cfp_pkg::ST2CK_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   cfp_if.host link,
   input wire logic [1:0] width_sel,
   input wire logic decomp_en,
   input wire logic secure_en,
   input wire logic start,
   input wire logic [cfp_pkg::DATA_W-1:0] in_data,
   input wire logic in_valid,
   input wire logic in_last,
   output logic in_ready,
   output logic busy,
   output logic done
);
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_WAIT = 4'b0010,
      H_RUN = 4'b0100,
      H_DONE = 4'b1000
   } cfp_hstate_t;

   localparam logic [cfp_pkg::TMR_W-1:0] HALF_LD = cfp_pkg::TMR_W'(HALF_CYCLES - 1);
   localparam logic [cfp_pkg::TMR_W-1:0] WAIT_LD = cfp_pkg::TMR_W'(WAIT_CYCLES - 1);

   cfp_hstate_t state_r, state_nxt;
   logic [cfp_pkg::TMR_W-1:0] tmr_r, tmr_nxt;
   logic clk_r, clk_nxt;
   logic [cfp_pkg::DATA_W-1:0] data_r;
   logic last_r;
   logic [3:0] left_r, left_nxt;
   logic [3:0] ratio_r;
   logic st_s1_r, st_s2_r;

   // ------------------------------------------------------------
   // Status synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_s1_r <= 1'b0;
         st_s2_r <= 1'b0;
      end else begin
         st_s1_r <= link.status_n;
         st_s2_r <= st_s1_r;
      end
   end

   wire tmr_done = (tmr_r == '0);
   wire run = (state_r == H_RUN);
   wire need_word = run && !clk_r && tmr_done && (left_r == 4'h0) && !last_r;
   wire load = need_word && in_valid;
   wire rise = run && !clk_r && tmr_done && (left_r != 4'h0);
   wire fall = run && clk_r && tmr_done;
   // Last word's ratio edges include the ratio-1 trailing ones
   wire finished = fall && (left_r == 4'h0) && last_r;

   assign in_ready = need_word;
   assign busy = (state_r == H_WAIT) || run;
   assign done = (state_r == H_DONE);
   assign link.config_clock = clk_r;
   assign link.data = data_r;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      tmr_nxt = tmr_done ? tmr_r : tmr_r - cfp_pkg::TMR_W'(1);
      clk_nxt = clk_r;
      left_nxt = left_r;
      unique case (state_r)
         H_IDLE: begin
            if (start && st_s2_r) begin
               state_nxt = H_WAIT;
               tmr_nxt = WAIT_LD;
            end
         end
         H_WAIT: begin
            if (!st_s2_r) begin
               state_nxt = H_IDLE;
            end else if (tmr_done) begin
               state_nxt = H_RUN;
               tmr_nxt = HALF_LD;
            end
         end
         H_RUN: begin
            if (!st_s2_r) begin
               state_nxt = H_IDLE;
               clk_nxt = 1'b0;
               left_nxt = 4'h0;
            end else if (load) begin
               left_nxt = ratio_r;
               tmr_nxt = HALF_LD;
            end else if (rise) begin
               clk_nxt = 1'b1;
               left_nxt = left_r - 4'h1;
               tmr_nxt = HALF_LD;
            end else if (fall) begin
               clk_nxt = 1'b0;
               tmr_nxt = HALF_LD;
               if (finished) begin
                  state_nxt = H_DONE;
               end
            end
         end
         H_DONE: begin
            if (!start) begin
               state_nxt = H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r <= H_IDLE;
         tmr_r <= '0;
         clk_r <= 1'b0;
         left_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         tmr_r <= tmr_nxt;
         clk_r <= clk_nxt;
         left_r <= left_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ratio_r <= cfp_pkg::RATIO_PLAIN;
         data_r <= '0;
         last_r <= 1'b0;
      end else begin
         if (state_r == H_IDLE) begin
            ratio_r <= cfp_pkg::cfp_ratio(width_sel, decomp_en, secure_en);
            last_r <= 1'b0;
         end
         if (load) begin
            data_r <= in_data;
            last_r <= in_last;
         end
      end
   end
endmodule
`default_nettype wire

/* cfp_pkg.sv */
// Purpose: Shared constants for the parallel passive load pacing link.
// Assumes: mclk at 200 MHz on both ends.
// Notes: Clocks-per-word ratio is derived here so both ends agree.
//
// Behaviour
// - Both features off: one clock per word
// - x8: 1/2, x16: 2/4 clocks per word
// - x32: 4 secure-only, 8 with decompression
// - Host clock is ratio times word rate
// - Device spends extra edges decrypting and decompressing
// - Host runs ratio minus one edges after last
// - Clock at most 100 MHz x32, 125 otherwise
// - Host waits 2 us after status rises
package cfp_pkg;
   // ------------------------------------------------------------
   // Bus width codes
   // ------------------------------------------------------------
   localparam logic [1:0] WIDTH_X8 = 2'h0;
   localparam logic [1:0] WIDTH_X16 = 2'h1;
   localparam logic [1:0] WIDTH_X32 = 2'h2;
   localparam int DATA_W = 32;
   localparam int RATIO_W = 4;

   // ------------------------------------------------------------
   // Clocks-per-word ratios
   // ------------------------------------------------------------
   localparam logic [3:0] RATIO_PLAIN = 4'h1;
   localparam logic [3:0] RATIO_X8_SEC = 4'h1;
   localparam logic [3:0] RATIO_X8_DC = 4'h2;
   localparam logic [3:0] RATIO_X16_SEC = 4'h2;
   localparam logic [3:0] RATIO_X16_DC = 4'h4;
   localparam logic [3:0] RATIO_X32_SEC = 4'h4;
   localparam logic [3:0] RATIO_X32_DC = 4'h8;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int MCLK_PERIOD_PS = 5000;
   localparam int CLK_MAX_X32_MHZ = 100;
   localparam int CLK_MAX_X16_MHZ = 125;
   localparam int CLK_MIN_PERIOD_PS = 1000000 / CLK_MAX_X32_MHZ;
   localparam int CLK_MIN_PERIOD_CYC =
      (CLK_MIN_PERIOD_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
   localparam int CLK_HALF_CYC = (CLK_MIN_PERIOD_CYC + 1) / 2;
   localparam int ST2CK_US = 2;
   localparam int ST2CK_CYC = (ST2CK_US * 1000000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
   localparam int TMR_W = 16;
   localparam int FIFO_DEPTH = 4;

   function automatic logic [3:0] cfp_ratio(input logic [1:0] width, input logic dc,
                                            input logic sec);
      logic [3:0] r;
      r = RATIO_PLAIN;
      if (width == WIDTH_X8) begin
         r = dc ? RATIO_X8_DC : (sec ? RATIO_X8_SEC : RATIO_PLAIN);
      end else if (width == WIDTH_X16) begin
         r = dc ? RATIO_X16_DC : (sec ? RATIO_X16_SEC : RATIO_PLAIN);
      end else begin
         r = dc ? RATIO_X32_DC : (sec ? RATIO_X32_SEC : RATIO_PLAIN);
      end
      return r;
   endfunction
endpackage

/* cfp_if.sv */
// Purpose: Pins of the parallel passive load link.
// Assumes: Host makes config_clock; device drives status_n.
// Notes: No clocking block; both ends sample with mclk.
`timescale 1ns/1ps
`default_nettype none
interface cfp_if;
   logic config_clock;
   logic [cfp_pkg::DATA_W-1:0] data;
   logic status_n;

   modport device (
      input config_clock,
      input data,
      output status_n
   );
   modport host (
      output config_clock,
      output data,
      input status_n
   );
endinterface
`default_nettype wire

/* cfp_device.sv */
// Purpose: Device end: samples config_clock, paces words into a FIFO.
// Assumes: Host keeps its side of the ratio and tail edges.
// Notes: Overflow of the FIFO pulls status_n low as a load error.
`timescale 1ns/1ps
`default_nettype none
module cfp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
   wire empty = (wr_r == rd_r);
   wire do_wr = in_valid && !full;
   wire do_rd = out_valid && out_ready;

   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_r[rd_r[AW-1:0]];

   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem_r[wr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         wr_r <= wr_r + (AW+1)'(do_wr);
         rd_r <= rd_r + (AW+1)'(do_rd);
      end
   end
endmodule

module cfp_device (
   input wire logic mclk,
   input wire logic reset,
   cfp_if.device link,
   input wire logic [1:0] width_sel,
   input wire logic decomp_en,
   input wire logic secure_en,
   input wire logic enable,
   output logic [cfp_pkg::DATA_W-1:0] word_data,
   output logic word_valid,
   input wire logic word_ready,
   output logic load_err
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic ck_s1_r, ck_s2_r, ck_s3_r;
   logic [cfp_pkg::DATA_W-1:0] d_s1_r, d_s2_r;
   always_ff @(posedge mclk) begin
      if (reset) begin
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
         d_s1_r <= '0;
         d_s2_r <= '0;
      end else begin
         ck_s1_r <= link.config_clock;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
         d_s1_r <= link.data;
         d_s2_r <= d_s1_r;
      end
   end

   // ------------------------------------------------------------
   // Word pacing
   // ------------------------------------------------------------
   logic [3:0] left_r;
   logic [cfp_pkg::DATA_W-1:0] word_r;
   logic push_r;
   logic err_r;
   logic fifo_ready;
   wire rise = ck_s2_r && !ck_s3_r && enable && !err_r;
   wire [3:0] ratio = cfp_pkg::cfp_ratio(width_sel, decomp_en, secure_en);
   wire new_word = rise && (left_r == 4'h0);
   wire [cfp_pkg::DATA_W-1:0] masked =
      (width_sel == cfp_pkg::WIDTH_X8) ? {24'h000000, d_s2_r[7:0]} :
      (width_sel == cfp_pkg::WIDTH_X16) ? {16'h0000, d_s2_r[15:0]} : d_s2_r;
   // Word is handed on only after its extra edges are spent
   wire finish = (new_word && ratio == cfp_pkg::RATIO_PLAIN) ||
                 (rise && left_r == 4'h1);
   wire [3:0] left_nxt = new_word ? ratio - 4'h1 : (rise ? left_r - 4'h1 : left_r);

   always_ff @(posedge mclk) begin
      if (reset || !enable) begin
         left_r <= 4'h0;
         push_r <= 1'b0;
         word_r <= '0;
      end else begin
         left_r <= left_nxt;
         push_r <= finish;
         if (new_word) begin
            word_r <= masked;
         end
      end
   end

   // Push finds FIFO full: the stream cannot be paused, so flag it
   always_ff @(posedge mclk) begin
      if (reset || !enable) begin
         err_r <= 1'b0;
      end else if (push_r && !fifo_ready) begin
         err_r <= 1'b1;
      end
   end

   logic stat_n_r;
   always_ff @(posedge mclk) begin
      if (reset) begin
         stat_n_r <= 1'b0;
      end else begin
         stat_n_r <= enable && !err_r && !(push_r && !fifo_ready);
      end
   end
   assign link.status_n = stat_n_r;
   assign load_err = err_r;

   cfp_fifo #(
      .WIDTH(cfp_pkg::DATA_W),
      .DEPTH(cfp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .in_data(word_r),
      .in_valid(push_r),
      .in_ready(fifo_ready),
      .out_data(word_data),
      .out_valid(word_valid),
      .out_ready(word_ready)
   );
endmodule
`default_nettype wire

/* cfp_link_asserts.sv */
// Purpose: Wire checks on the pacing link between host and device.
// Assumes: Host built with HALF_CYCLES 6 and WAIT_CYCLES 8.
// Notes: Repeat counts are literal; keep them in step with the bench.
`timescale 1ns/1ps
`default_nettype none
module cfp_link_asserts #(
   parameter int WAIT = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic config_clock,
   input wire logic [cfp_pkg::DATA_W-1:0] data,
   input wire logic status_n
);
   // ------------------------------------------------------------
   // Status high age, saturating
   // ------------------------------------------------------------
   logic [7:0] st_cnt_r;
   always_ff @(posedge mclk) begin
      if (reset || !status_n) begin
         st_cnt_r <= 8'h00;
      end else if (st_cnt_r != 8'hFF) begin
         st_cnt_r <= st_cnt_r + 8'h01;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   chk_data_held_high: assert property (config_clock && $past(config_clock) |-> $stable(data))
      else $error("data moved while config_clock high");
   chk_data_setup_edge: assert property ($rose(config_clock) |-> $stable(data))
      else $error("data moved with the rising config_clock");
   chk_high_phase_len: assert property ($rose(config_clock) |=> config_clock[*5] ##1 !config_clock)
      else $error("config_clock high phase not six cycles");
   chk_low_phase_min: assert property ($fell(config_clock) |=> (!config_clock)[*5])
      else $error("config_clock low phase too short");
   chk_rise_gap: assert property ($rose(config_clock) |=> (!$rose(config_clock))[*8])
      else $error("config_clock rising edges too close");
   chk_wait_after_status: assert property ($rose(config_clock) |-> int'(st_cnt_r) >= WAIT)
      else $error("config_clock rose too soon after status");
   chk_first_edge_quiet: assert property ($rose(status_n) |-> (!config_clock)[*8])
      else $error("config_clock ran right after status rose");
   chk_stop_on_status: assert property ((!status_n)[*8] |-> !config_clock)
      else $error("config_clock running while status low");
endmodule
`default_nettype wire

/* tb_parallel_config_clock_pacing.sv */
// Purpose: Host and device joined back to back, streams in every mode.
// Assumes: Host HALF_CYCLES 6 gives a 60 ns link clock.
// Notes: Overflow case stalls the sink side until the FIFO refuses.
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_config_clock_pacing;
   // ------------------------------------------------------------
   // Stimulus, monitor and verdict
   // ------------------------------------------------------------
   localparam int RT[12] = '{1, 1, 2, 2, 1, 2, 4, 4, 1, 4, 8, 8};
   logic mclk, reset = 1'b1, decomp_en = 1'b0, secure_en = 1'b0, start = 1'b0;
   logic in_valid = 1'b0, in_last = 1'b0, word_ready = 1'b0, stall = 1'b1;
   logic [1:0] width_sel = 2'h0;
   logic [31:0] in_data = 32'h0, word_data;
   logic word_valid, load_err, in_ready, busy, done;
   logic dev_en = 1'b1;
   logic [31:0] exp_q[$];
   int err_total = 0, checks_done = 0, edges = 0;
   cfp_if cfp_if_i ();
   cfp_host #(.HALF_CYCLES(6), .WAIT_CYCLES(8)) cfp_host_i (.mclk(mclk), .reset(reset),
      .link(cfp_if_i), .width_sel(width_sel), .decomp_en(decomp_en), .secure_en(secure_en),
      .start(start), .in_data(in_data), .in_valid(in_valid), .in_last(in_last),
      .in_ready(in_ready), .busy(busy), .done(done));
   cfp_device cfp_device_i (.mclk(mclk), .reset(reset), .link(cfp_if_i),
      .width_sel(width_sel), .decomp_en(decomp_en), .secure_en(secure_en), .enable(dev_en),
      .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
      .load_err(load_err));
   cfp_link_asserts #(.WAIT(8)) cfp_link_asserts_i (.mclk(mclk), .reset(reset),
      .config_clock(cfp_if_i.config_clock), .data(cfp_if_i.data),
      .status_n(cfp_if_i.status_n));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge cfp_if_i.config_clock) edges++;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Ready chosen first so the compare sees what the next edge pops
   always @(negedge mclk) begin
      word_ready = stall ? 1'b0 : ($urandom_range(3) != 0);
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
         check(word_data, exp_q.size() != 0 ? exp_q.pop_front() : 32'hX);
      end
   end
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic feed(input int n, input int keep, input logic [31:0] mask);
      int t;
      for (int i = 0; i < n; i++) begin
         in_data = $urandom;
         in_valid = 1'b1;
         in_last = (i == n - 1);
         t = 0;
         while (in_ready !== 1'b1 && t < 3000) begin
            @(negedge mclk);
            t++;
         end
         if (t == 3000) err_total++;
         if (i < keep) exp_q.push_back(in_data & mask);
         @(negedge mclk);
      end
      in_valid = 1'b0;
      in_last = 1'b0;
   endtask
   task automatic run(input logic [1:0] w, input logic dc, input logic sc, input int r);
      int e0;
      int t;
      width_sel = w;
      decomp_en = dc;
      secure_en = sc;
      start = 1'b1;
      e0 = edges;
      feed(4, 4, w == 2'h0 ? 32'hFF : (w == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF));
      t = 0;
      while (done !== 1'b1 && t < 3000) begin
         @(negedge mclk);
         t++;
      end
      check(done, 1'b1);
      check(busy, 1'b0);
      repeat (200) @(negedge mclk);
      // Last word is latched at its first edge, so its ratio-1 tail is inside 4*r
      check(32'(edges - e0), 32'(4 * r));
      check(32'(exp_q.size()), 32'h0);
      start = 1'b0;
      repeat (4) @(negedge mclk);
   endtask
   initial begin
      #400000;
      err_total++;
      give_verdict();
   end
   initial begin
      void'($urandom(34));
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      // Stalled sink: four words fit, the fifth is refused
      width_sel = 2'h2;
      start = 1'b1;
      feed(5, 4, 32'hFFFFFFFF);
      repeat (100) @(negedge mclk);
      check(load_err, 1'b1);
      stall = 1'b0;
      repeat (100) @(negedge mclk);
      check(32'(exp_q.size()), 32'h0);
      start = 1'b0;
      repeat (4) @(negedge mclk);
      check(busy, 1'b0);
      // Dropping enable clears the sticky error without a reset
      dev_en = 1'b0;
      repeat (2) @(negedge mclk);
      check(load_err, 1'b0);
      dev_en = 1'b1;
      repeat (20) @(negedge mclk);
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      check(load_err, 1'b0);
      for (int w = 0; w < 3; w++) begin
         for (int k = 0; k < 4; k++) begin
            run(2'(w), k[1], k[0], RT[w * 4 + k]);
         end
      end
      give_verdict();
   end
endmodule
`default_nettype wire
